/* File: src/char_forms.sv */
// Character conversions: numeric form, overpunched form and zero-digit test.
// Assumes a character in the low bits; 6-bit codes use bits 5:0 only.
`default_nettype none
`include "edit_unit_regs.svh"

module char_forms (
   // Character and destination size
   input  wire logic [`CHR_W-1:0] chr_i,
   input  wire logic              dst8_i,
   // Converted forms
   output logic      [`CHR_W-1:0] numeric_o,
   output logic      [`CHR_W-1:0] overpunch_o,
   output logic                   digit_zero_o
);

   always_comb begin
      if (dst8_i) begin
         numeric_o   = {`ZONE_NUM_8, chr_i[3:0]};
         overpunch_o = {`ZONE_OVP_8, chr_i[3:0]};
      end else begin
         numeric_o   = {2'b00, `ZONE_NUM_6, chr_i[3:0]};
         overpunch_o = {2'b00, `ZONE_OVP_6, chr_i[3:0]};
      end
      digit_zero_o = (chr_i[3:0] == 4'h0);
   end

endmodule : char_forms

`default_nettype wire

/* File: src/edit_micro_operator_unit.sv */
// Edit micro-operator engine with a classic Wishbone register slave.
// Assumes one character per memory address and a memory port on the same clock.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
`include "edit_unit_regs.svh"

// Summary of operation
// - Move characters copies source to destination, count from syllable or stack.
// - Move numeric copies low four bits, zone 00 or 1111 by size.
// - Move with insert: table repeat then insert char; single: stack, next syllable.
// - Float clear and zero digit inserts; else set float, write numeric.
// - Move with float: repeat and three inserts from syllables, or stack repeat.
// - Float clear, zero digit: write first insert character.
// - Float clear, nonzero: set float, sign-chosen insert, then numeric char.
// - Float set: write numeric; decision repeats for whole count.
// - Skips move source or destination pointer forward or back, no data.
// - Skip count from stack when single, from next syllable in table.
// - Reset float clears float flag, no transfer.
// - End float writes sign-chosen character when float clear; else clears float.
// - Insert unconditional writes insert character repeat count times.
// - Insert conditional writes first or second character by float flag.
// - Its two characters follow repeat syllable, or operator syllable singly.
// - Display sign writes second or third syllable character by sign.
// - Overpunch sets destination zone 10 or 1101 when sign is one.
// - End edit terminates table-driven execution.
// - Protected source or destination data aborts with segmented-array flag.
// - Entry singly from registers or by table fetched from memory.
module edit_micro_operator_unit
   import edit_unit_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Character memory port
   output logic                   mem_req_o,
   output logic                   mem_we_o,
   output logic      [`PTR_W-1:0] mem_addr_o,
   output logic      [`CHR_W-1:0] mem_wdata_o,
   input  wire logic [`CHR_W-1:0] mem_rdata_i,
   input  wire logic              mem_protect_i,
   input  wire logic              mem_ack_i,
   // Status
   output logic                   busy_o,
   output logic                   seg_array_o
);

   // ****************************************************************
   // Operator decoding
   // ****************************************************************
   function automatic logic has_count(input logic [7:0] op);
      case (op)
         `OP_MOVE_WITH_INSERT, `OP_MOVE_WITH_FLOAT, `OP_SKIP_FWD_SRC,
         `OP_SKIP_REV_SRC, `OP_MOVE_NUMERIC, `OP_MOVE_CHARACTERS,
         `OP_SKIP_FWD_DST, `OP_SKIP_REV_DST, `OP_INSERT_UNCOND,
         `OP_INSERT_COND: has_count = 1'b1;
         default:         has_count = 1'b0;
      endcase
   endfunction : has_count

   function automatic logic [2:0] table_syls(input logic [7:0] op);
      case (op)
         `OP_MOVE_WITH_FLOAT:                        table_syls = 3'd4;
         `OP_INSERT_COND:                            table_syls = 3'd3;
         `OP_MOVE_WITH_INSERT, `OP_INSERT_UNCOND,
         `OP_END_FLOAT, `OP_INSERT_DISPLAY_SIGN:     table_syls = 3'd2;
         `OP_SKIP_FWD_SRC, `OP_SKIP_REV_SRC, `OP_MOVE_NUMERIC,
         `OP_MOVE_CHARACTERS, `OP_SKIP_FWD_DST,
         `OP_SKIP_REV_DST:                           table_syls = 3'd1;
         default:                                    table_syls = 3'd0;
      endcase
   endfunction : table_syls

   // ****************************************************************
   // State and derived values
   // ****************************************************************
   state_t                q;
   state_t                next_q;
   logic   [`CHR_W-1:0]   numeric;
   logic   [`CHR_W-1:0]   overpunch;
   logic                  digit_zero;
   logic                  in_table_count;
   logic   [`PTR_W-1:0]   count_val;
   logic   [7:0]          ins1;
   logic   [7:0]          ins2;
   logic   [7:0]          ins3;
   logic                  bus_wr;

   char_forms forms (
      .chr_i        (mem_rdata_i),
      .dst8_i       (q.dst8),
      .numeric_o    (numeric),
      .overpunch_o  (overpunch),
      .digit_zero_o (digit_zero)
   );

   assign in_table_count = q.table_mode && has_count(q.op);
   assign count_val      = in_table_count ? {12'h000, q.syl[0]} : q.tos;
   assign ins1           = in_table_count ? q.syl[1] : q.syl[0];
   assign ins2           = in_table_count ? q.syl[2] : q.syl[1];
   assign ins3           = in_table_count ? q.syl[3] : q.syl[2];
   assign bus_wr         = cyc_i && stb_i && we_i && q.ack;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_q = q;

      // Bus slave: one-cycle answer, ack dropped the cycle after
      next_q.ack  = cyc_i && stb_i && !q.ack;
      next_q.rdat = 32'h0000_0000;
      case (adr_i)
         `OFS_CTRL:   next_q.rdat = {28'h0, q.sign, q.dst8, q.table_mode, 1'b0};
         `OFS_STATUS: next_q.rdat = {28'h0, q.bad, q.prot, q.flt, q.busy};
         `OFS_SYL:    next_q.rdat = {q.syl_reg, q.op};
         `OFS_TOS:    next_q.rdat = {12'h000, q.tos};
         `OFS_SRC:    next_q.rdat = {12'h000, q.src};
         `OFS_DST:    next_q.rdat = {12'h000, q.dst};
         `OFS_TBL:    next_q.rdat = {12'h000, q.tbl};
         default:     next_q.rdat = 32'h0000_0000;
      endcase

      if (bus_wr && !q.busy) begin
         case (adr_i)
            `OFS_CTRL: begin
               if (sel_i[0]) begin
                  next_q.table_mode = dat_i[`CTRL_TABLE];
                  next_q.dst8       = dat_i[`CTRL_DST8];
                  next_q.sign       = dat_i[`CTRL_SIGN];
                  if (dat_i[`CTRL_START]) begin
                     next_q.busy = 1'b1;
                     next_q.prot = 1'b0;
                     next_q.bad  = 1'b0;
                     if (dat_i[`CTRL_TABLE]) begin
                        next_q.st = S_FETCH_OP;
                     end else begin
                        next_q.st  = S_EXEC;
                        next_q.syl = {8'h00, q.syl_reg};
                     end
                  end
               end
            end
            `OFS_SYL: begin
               if (sel_i[0]) next_q.op         = dat_i[7:0];
               if (sel_i[1]) next_q.syl_reg[0] = dat_i[15:8];
               if (sel_i[2]) next_q.syl_reg[1] = dat_i[23:16];
               if (sel_i[3]) next_q.syl_reg[2] = dat_i[31:24];
            end
            `OFS_TOS: next_q.tos = dat_i[`PTR_W-1:0];
            `OFS_SRC: next_q.src = dat_i[`PTR_W-1:0];
            `OFS_DST: next_q.dst = dat_i[`PTR_W-1:0];
            `OFS_TBL: next_q.tbl = dat_i[`PTR_W-1:0];
            default: begin
            end
         endcase
      end

      // Edit sequencer
      case (q.st)
         S_IDLE: begin
         end
         S_FETCH_OP, S_FETCH_SYL: begin
            if (!q.req) begin
               next_q.req  = 1'b1;
               next_q.we   = 1'b0;
               next_q.addr = q.tbl;
            end else if (mem_ack_i) begin
               next_q.req = 1'b0;
               next_q.tbl = q.tbl + 1'b1;
               if (q.st == S_FETCH_OP) begin
                  next_q.op  = mem_rdata_i;
                  next_q.idx = 3'd0;
                  next_q.st  = (table_syls(mem_rdata_i) == 3'd0) ? S_EXEC : S_FETCH_SYL;
               end else begin
                  next_q.syl[q.idx[1:0]] = mem_rdata_i;
                  next_q.idx             = q.idx + 3'd1;
                  if (q.idx + 3'd1 == table_syls(q.op)) next_q.st = S_EXEC;
               end
            end
         end
         S_EXEC: begin
            next_q.cnt  = count_val;
            next_q.pend = 1'b0;
            next_q.st   = S_NEXT;
            case (q.op)
               `OP_SKIP_FWD_SRC: next_q.src = q.src + count_val;
               `OP_SKIP_REV_SRC: next_q.src = q.src - count_val;
               `OP_SKIP_FWD_DST: next_q.dst = q.dst + count_val;
               `OP_SKIP_REV_DST: next_q.dst = q.dst - count_val;
               `OP_RESET_FLOAT:  next_q.flt = 1'b0;
               `OP_END_FLOAT: begin
                  if (q.flt) begin
                     next_q.flt = 1'b0;
                  end else begin
                     next_q.wdat = q.sign ? q.syl[0] : q.syl[1];
                     next_q.cnt  = {{(`PTR_W-1){1'b0}}, 1'b1};
                     next_q.st   = S_WR;
                  end
               end
               `OP_INSERT_DISPLAY_SIGN: begin
                  next_q.wdat = q.sign ? q.syl[0] : q.syl[1];
                  next_q.cnt  = {{(`PTR_W-1){1'b0}}, 1'b1};
                  next_q.st   = S_WR;
               end
               `OP_INSERT_OVERPUNCH: begin
                  if (q.sign) next_q.st = S_RD_DST;
               end
               `OP_END_EDIT: begin
                  next_q.busy = 1'b0;
                  next_q.st   = S_IDLE;
               end
               `OP_MOVE_CHARACTERS, `OP_MOVE_NUMERIC, `OP_MOVE_WITH_INSERT,
               `OP_MOVE_WITH_FLOAT, `OP_INSERT_UNCOND, `OP_INSERT_COND: begin
                  next_q.st = S_ELEM;
               end
               default: begin
                  next_q.bad  = 1'b1;
                  next_q.busy = 1'b0;
                  next_q.st   = S_IDLE;
               end
            endcase
         end
         S_ELEM: begin
            if (q.cnt == '0) begin
               next_q.st = S_NEXT;
            end else if (q.op == `OP_INSERT_UNCOND) begin
               next_q.wdat = ins1;
               next_q.st   = S_WR;
            end else if (q.op == `OP_INSERT_COND) begin
               next_q.wdat = q.flt ? ins2 : ins1;
               next_q.st   = S_WR;
            end else begin
               next_q.st = S_RD_SRC;
            end
         end
         S_RD_SRC: begin
            if (!q.req) begin
               next_q.req  = 1'b1;
               next_q.we   = 1'b0;
               next_q.addr = q.src;
            end else if (mem_ack_i) begin
               next_q.req = 1'b0;
               next_q.src = q.src + 1'b1;
               next_q.st  = S_WR;
               case (q.op)
                  `OP_MOVE_CHARACTERS: next_q.wdat = mem_rdata_i;
                  `OP_MOVE_NUMERIC:    next_q.wdat = numeric;
                  `OP_MOVE_WITH_INSERT: begin
                     if (!q.flt && digit_zero) begin
                        next_q.wdat = ins1;
                     end else begin
                        next_q.flt  = 1'b1;
                        next_q.wdat = numeric;
                     end
                  end
                  default: begin
                     if (!q.flt && digit_zero) begin
                        next_q.wdat = ins1;
                     end else if (!q.flt) begin
                        next_q.flt  = 1'b1;
                        next_q.wdat = q.sign ? ins2 : ins3;
                        next_q.pend = 1'b1;
                        next_q.pnum = numeric;
                     end else begin
                        next_q.wdat = numeric;
                     end
                  end
               endcase
               if (mem_protect_i) begin
                  next_q.prot = 1'b1;
                  next_q.busy = 1'b0;
                  next_q.st   = S_IDLE;
               end
            end
         end
         S_RD_DST: begin
            if (!q.req) begin
               next_q.req  = 1'b1;
               next_q.we   = 1'b0;
               next_q.addr = q.dst;
            end else if (mem_ack_i) begin
               next_q.req  = 1'b0;
               next_q.wdat = overpunch;
               next_q.cnt  = {{(`PTR_W-1){1'b0}}, 1'b1};
               next_q.st   = S_WR;
               if (mem_protect_i) begin
                  next_q.prot = 1'b1;
                  next_q.busy = 1'b0;
                  next_q.st   = S_IDLE;
               end
            end
         end
         S_WR: begin
            if (!q.req) begin
               next_q.req  = 1'b1;
               next_q.we   = 1'b1;
               next_q.addr = q.dst;
            end else if (mem_ack_i) begin
               next_q.req = 1'b0;
               next_q.we  = 1'b0;
               next_q.dst = q.dst + 1'b1;
               if (q.pend) begin
                  next_q.pend = 1'b0;
                  next_q.wdat = q.pnum;
               end else if (q.cnt <= {{(`PTR_W-1){1'b0}}, 1'b1}) begin
                  next_q.cnt = '0;
                  next_q.st  = S_NEXT;
               end else begin
                  next_q.cnt = q.cnt - 1'b1;
                  next_q.st  = S_ELEM;
               end
               if (mem_protect_i) begin
                  next_q.prot = 1'b1;
                  next_q.busy = 1'b0;
                  next_q.st   = S_IDLE;
               end
            end
         end
         S_NEXT: begin
            if (q.table_mode) begin
               next_q.st = S_FETCH_OP;
            end else begin
               next_q.busy = 1'b0;
               next_q.st   = S_IDLE;
            end
         end
         default: begin
            next_q.st = S_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // State register and outputs
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q    <= '0;
         q.st <= S_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign dat_o       = q.rdat;
   assign ack_o       = q.ack;
   assign mem_req_o   = q.req;
   assign mem_we_o    = q.we;
   assign mem_addr_o  = q.addr;
   assign mem_wdata_o = q.wdat;
   assign busy_o      = q.busy;
   assign seg_array_o = q.prot;

endmodule : edit_micro_operator_unit

`default_nettype wire

/* File: src/edit_unit_pkg.sv */
// Types of the edit unit: sequencer states and the packed state record.
// Assumes edit_unit_regs.svh is on the include path.
`default_nettype none
`include "edit_unit_regs.svh"

package edit_unit_pkg;

   typedef enum logic [3:0] {
      S_IDLE,
      S_FETCH_OP,
      S_FETCH_SYL,
      S_EXEC,
      S_ELEM,
      S_RD_SRC,
      S_RD_DST,
      S_WR,
      S_NEXT
   } seq_t;

   typedef struct packed {
      seq_t                    st;
      logic                    ack;
      logic [31:0]             rdat;
      logic                    busy;
      logic                    table_mode;
      logic                    dst8;
      logic                    sign;
      logic                    flt;
      logic                    prot;
      logic                    bad;
      logic [7:0]              op;
      logic [2:0][7:0]         syl_reg;
      logic [3:0][7:0]         syl;
      logic [2:0]              idx;
      logic [`PTR_W-1:0]       tos;
      logic [`PTR_W-1:0]       cnt;
      logic [`PTR_W-1:0]       src;
      logic [`PTR_W-1:0]       dst;
      logic [`PTR_W-1:0]       tbl;
      logic                    pend;
      logic [`CHR_W-1:0]       pnum;
      logic                    req;
      logic                    we;
      logic [`PTR_W-1:0]       addr;
      logic [`CHR_W-1:0]       wdat;
   } state_t;

endpackage : edit_unit_pkg

`default_nettype wire

/* File: src/edit_unit_regs.svh */
// Register offsets, field positions, reset values and operator codes of the edit unit.
// Assumes a 32-bit classic Wishbone slave and a character-addressed memory port.
`ifndef EDIT_UNIT_REGS_SVH
`define EDIT_UNIT_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define PTR_W           20
`define CHR_W           8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_SYL         8'h08
`define OFS_TOS         8'h0C
`define OFS_SRC         8'h10
`define OFS_DST         8'h14
`define OFS_TBL         8'h18

// ****************************************************************
// Control and status bits
// ****************************************************************
`define CTRL_START      0
`define CTRL_TABLE      1
`define CTRL_DST8       2
`define CTRL_SIGN       3
`define STAT_BUSY       0
`define STAT_FLOAT      1
`define STAT_PROT       2
`define STAT_BADOP      3
`define RST_WORD        32'h0000_0000

// ****************************************************************
// Micro-operator codes
// ****************************************************************
`define OP_MOVE_WITH_INSERT     8'hD0
`define OP_MOVE_WITH_FLOAT      8'hD1
`define OP_SKIP_FWD_SRC         8'hD2
`define OP_SKIP_REV_SRC         8'hD3
`define OP_RESET_FLOAT          8'hD4
`define OP_END_FLOAT            8'hD5
`define OP_MOVE_NUMERIC         8'hD6
`define OP_MOVE_CHARACTERS      8'hD7
`define OP_INSERT_OVERPUNCH     8'hD8
`define OP_INSERT_DISPLAY_SIGN  8'hD9
`define OP_SKIP_FWD_DST         8'hDA
`define OP_SKIP_REV_DST         8'hDB
`define OP_INSERT_UNCOND        8'hDC
`define OP_INSERT_COND          8'hDD
`define OP_END_EDIT             8'hDE

// ****************************************************************
// Zone codes
// ****************************************************************
`define ZONE_NUM_6      2'b00
`define ZONE_NUM_8      4'hF
`define ZONE_OVP_6      2'b10
`define ZONE_OVP_8      4'hD

`endif

/* File: tb/char_mem_model.sv */
// Character memory that answers the edit unit's memory port.
// Assumes addresses F0 to FF hold protected data; answer delay set by the bench.
`default_nettype none
`include "edit_unit_regs.svh"
module char_mem_model (
   // Clock, reset and request
   input  wire logic              clk_i, rst_i, req_i, we_i,
   input  wire logic [`PTR_W-1:0] addr_i,
   input  wire logic [`CHR_W-1:0] wdata_i,
   input  wire logic [3:0]        delay_i,
   // Answer
   output var  logic [`CHR_W-1:0] rdata_o,
   output var  logic              ack_o, prot_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [3:0] wait_n;
   initial {rdata_o, ack_o, prot_o, wait_n} = {8'hA5, 1'b0, 1'b0, 4'h0};
   // Outside an answer the data and protect lines keep changing
   always @(posedge clk_i) begin
      {rdata_o, prot_o, ack_o, wait_n} <= {~rdata_o, ~prot_o, 1'b0, 4'h0};
      if (!rst_i && req_i && !ack_o) begin
         wait_n <= wait_n + 4'h1;
         if (wait_n >= delay_i) begin
            {ack_o, rdata_o, prot_o} <= {1'b1, mem[addr_i[7:0]], addr_i[7:4] == 4'hF};
            if (we_i)
               mem[addr_i[7:0]] <= wdata_i;
         end
      end
   end
endmodule : char_mem_model
`default_nettype wire

/* File: tb/edit_unit_props.sv */
// Checker of the edit unit's bus and memory port timing.
// Assumes a bind onto edit_micro_operator_unit; one clock, synchronous reset.
`default_nettype none
`include "edit_unit_regs.svh"
module edit_unit_props (
   // Clock, reset and bus
   input wire logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [7:0]        adr_i,
   input wire logic [3:0]        sel_i,
   input wire logic [31:0]       dat_i, dat_o,
   // Memory port and status
   input wire logic              mem_req_o, mem_we_o, mem_ack_i, mem_protect_i,
   input wire logic [`PTR_W-1:0] mem_addr_o,
   input wire logic [`CHR_W-1:0] mem_wdata_o,
   input wire logic              busy_o, seg_array_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic go;
   assign go = cyc_i && stb_i && we_i && adr_i == `OFS_CTRL && sel_i[0] && dat_i[`CTRL_START];
   AST_ACK_NEXT: assert property ($rose(cyc_i && stb_i) |=> ack_o)
      else $error("bus request not acked in next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_UNMAPPED: assert property (ack_o && !we_i && adr_i >= 8'h1C |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_START: assert property (go && ack_o && !busy_o |-> ##[1:2] busy_o)
      else $error("start did not raise busy");
   AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request changed");
   AST_REQ_GAP: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("memory request not dropped after answer");
   AST_PROT_ABORT: assert property (mem_req_o && mem_ack_i && mem_protect_i
      |-> ##[1:2] (seg_array_o && !busy_o && !mem_req_o)) else $error("protect did not abort");
   AST_SEG_STICKY: assert property (seg_array_o && !go |=> seg_array_o)
      else $error("protect flag lost without start");
   cover property (go && ack_o);
   cover property (mem_req_o && mem_ack_i && mem_we_o);
   cover property (mem_req_o && mem_ack_i && mem_protect_i);
endmodule : edit_unit_props
`default_nettype wire

/* File: tb/test_edit_micro_operator_unit.sv */
// Self-checking bench of the edit unit: single-micro rows, skips, table mode, protect.
// Assumes the character memory model and the checker bound below.
`default_nettype none
`include "edit_unit_regs.svh"
module test_edit_micro_operator_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, ack, mreq, mwe, mrd_ok, mprot, busy, seg;
   logic [7:0] adr, mwd, mrd;
   logic [3:0] sel, dly;
   logic [31:0] dat, rdat, q;
   logic [`PTR_W-1:0] maddr;
   logic [71:0] r;
   logic [111:0] tbl = 112'hD7_02_D2_01_DA_01_D6_01_DC_01_2A_DE_D7_01;
   int n_fail = 0, checks = 0;
   // Op, syllables 2 to 4, source, old dest, two dest chars, flags {adv, float, sign, dst8}
   logic [71:0] rows [20] = '{
      72'hD7_00_00_00_35_00_35_00_11, 72'hD6_00_00_00_35_00_F5_00_11,
      72'hD6_00_00_00_35_00_05_00_10, 72'hD0_2A_00_00_30_00_2A_00_11,
      72'hD0_2A_00_00_37_00_F7_00_15, 72'hD4_00_00_00_37_66_66_00_01,
      72'hD1_20_2B_2D_30_00_20_00_11, 72'hD1_20_2B_2D_32_00_2B_F2_27,
      72'hD1_20_2B_2D_34_00_F4_00_15, 72'hD5_2B_2D_00_34_66_66_00_01,
      72'hD5_2B_2D_00_34_00_2D_00_11, 72'hD5_2B_2D_00_34_00_2B_00_13,
      72'hDC_2A_00_00_34_00_2A_00_11, 72'hDD_41_42_00_34_00_41_00_11,
      72'hD0_2A_00_00_39_00_F9_00_15, 72'hDD_41_42_00_34_00_42_00_15,
      72'hD9_2B_2D_00_34_00_2B_00_17, 72'hD9_2B_2D_00_34_00_2D_00_15,
      72'hD8_00_00_00_34_35_D5_00_17, 72'hD8_00_00_00_34_35_35_00_05};
   edit_micro_operator_unit dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
      .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd),
      .mem_rdata_i(mrd), .mem_protect_i(mprot), .mem_ack_i(mrd_ok), .busy_o(busy),
      .seg_array_o(seg));
   char_mem_model store (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe),
      .addr_i(maddr), .wdata_i(mwd), .delay_i(dly), .rdata_o(mrd), .ack_o(mrd_ok),
      .prot_o(mprot));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask : wb
   task automatic run(input logic [31:0] syl, input logic [19:0] s, d, t, input logic [3:0] c);
      wb(1'b1, `OFS_SRC, 32'(s));
      wb(1'b1, `OFS_DST, 32'(d));
      wb(1'b1, `OFS_TOS, 32'(t));
      wb(1'b1, `OFS_SYL, syl);
      wb(1'b1, `OFS_CTRL, 32'(c));
      do wb(1'b0, `OFS_STATUS, 32'h0); while (q[`STAT_BUSY] !== 1'b0);
   endtask : run
   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      report_and_stop();
   end
   initial begin
      {rst_i, cyc, stb, we, adr, sel, dat, dly} = {4'h8, 8'h00, 4'hF, 32'h0, 4'h0};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         r = rows[i];
         {store.mem[8'h10], store.mem[8'h40], store.mem[8'h41]} = {r[39:24], 8'h00};
         run({r[47:40], r[55:48], r[63:56], r[71:64]}, 20'h10, 20'h40, 20'h1, {r[1:0], 2'b01});
         cmp(32'(store.mem[8'h40]), 32'(r[23:16]));
         cmp(32'(store.mem[8'h41]), 32'(r[15:8]));
         wb(1'b0, `OFS_DST, 32'h0);
         cmp(q, 32'h40 + 32'(r[5:4]));
         wb(1'b0, `OFS_STATUS, 32'h0);
         cmp(32'(q[`STAT_FLOAT]), 32'(r[2]));
      end
      run({24'h0, `OP_SKIP_REV_SRC}, 20'h20, 20'h40, 20'h3, 4'h1);
      wb(1'b0, `OFS_SRC, 32'h0);
      cmp(q, 32'h1D);
      run({24'h0, `OP_SKIP_REV_DST}, 20'h20, 20'h40, 20'h2, 4'h1);
      wb(1'b0, `OFS_DST, 32'h0);
      cmp(q, 32'h3E);
      dly <= 4'h3;
      for (int k = 0; k < 14; k++) store.mem[8'h80 + k] = tbl[111 - 8 * k -: 8];
      for (int k = 0; k < 4; k++) {store.mem[8'h10 + k], store.mem[8'h40 + k]} = {8'(8'h31 + k), 8'h55};
      wb(1'b1, `OFS_TBL, 32'h80);
      run(32'h0, 20'h10, 20'h40, 20'h0, 4'h7);
      cmp({store.mem[8'h40], store.mem[8'h41], store.mem[8'h42], store.mem[8'h43]},
          32'h3132_55F4);
      wb(1'b0, `OFS_SRC, 32'h0);
      cmp(q, 32'h14);
      wb(1'b0, `OFS_DST, 32'h0);
      cmp(q, 32'h45);
      cmp(32'(store.mem[8'h44]), 32'h2A);
      store.mem[8'h40] = 8'h66;
      run({24'h0, `OP_MOVE_CHARACTERS}, 20'hF0, 20'h40, 20'h1, 4'h5);
      wb(1'b0, `OFS_STATUS, 32'h0);
      cmp({31'h0, seg & q[`STAT_PROT]}, 32'h1);
      cmp(32'(store.mem[8'h40]), 32'h66);
      wb(1'b0, 8'hFC, 32'h0);
      cmp(q, 32'h0);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      cmp({30'h0, seg, busy}, 32'h0);
      wb(1'b0, `OFS_DST, 32'h0);
      cmp(q, 32'h0);
      report_and_stop();
   end
endmodule : test_edit_micro_operator_unit
bind edit_micro_operator_unit edit_unit_props chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_ack_i(mem_ack_i),
   .mem_protect_i(mem_protect_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
   .busy_o(busy_o), .seg_array_o(seg_array_o));
`default_nettype wire
